// >>> rtl/eic_map.svh
`ifndef EIC_MAP_SVH
`define EIC_MAP_SVH

// Register byte offsets.
`define EIC_OFS_ENABLE 8'h00
`define EIC_OFS_LVL_LO 8'h04
`define EIC_OFS_LVL_HI 8'h08
`define EIC_OFS_XCTRL 8'h0c
`define EIC_OFS_TFLAGS 8'h10
`define EIC_OFS_PFLAGS 8'h14
`define EIC_OFS_STATUS 8'h18
`define EIC_OFS_REQVIEW 8'h1c

// Enable register fields and low priority register write mask.
`define EIC_EN_GLOBAL 7
`define EIC_EN_WMASK 8'hbf
`define EIC_LVL_LO_WMASK 8'h3f

// External 2/3 control register fields.
`define EIC_X3_LVL_LO 7
`define EIC_X3_IRQ_ON 6
`define EIC_X3_PEND 5
`define EIC_X3_EDGE 4
`define EIC_X2_LVL_LO 3
`define EIC_X2_IRQ_ON 2
`define EIC_X2_PEND 1
`define EIC_X2_EDGE 0

// Timer/external 0/1 flag register fields.
`define EIC_TF_X0_EDGE 0
`define EIC_TF_X0_PEND 1
`define EIC_TF_X1_EDGE 2
`define EIC_TF_X1_PEND 3
`define EIC_TF_T0_WRAP 5
`define EIC_TF_T1_WRAP 7

// Serial and timer 2 flag register fields.
`define EIC_PF_RX_DONE 0
`define EIC_PF_TX_DONE 1
`define EIC_PF_T2_TRIG 6
`define EIC_PF_T2_WRAP 7

// Vector addresses: base plus step times polling position.
`define EIC_VEC_BASE 8'h03
`define EIC_VEC_STEP 8'h08

// Reset values.
`define EIC_RST_BYTE 8'h00
`define EIC_RST_LINES 4'hf

// AXI responses.
`define EIC_RESP_OKAY 2'h0
`define EIC_RESP_SLVERR 2'h2

`endif

// >>> rtl/eic_pkg.sv
package eic_pkg;

  typedef logic [1:0] eic_code_t;

  typedef struct packed {
    logic [7:0] ie;
    logic [5:0] ip;
    logic [7:0] level_high_bank;
    logic [1:0] x_lo;
    logic [1:0] x_en;
    logic [3:0] edge_sel;
    logic [3:0] pend;
    logic [1:0] tmr_wrap;
    logic t2_wrap;
    logic t2_trig;
    logic rx_done;
    logic tx_done;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] in_svc;
    logic req;
    logic [2:0] src;
    eic_code_t code;
    logic [7:0] vec;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eic_state_s;

endpackage

// >>> rtl/eic_ctrl.sv
// Function
// - Eight sources, each gated by own and global enable.
// - Global gate clear blocks every source.
// - Enable register bit layout, bit 6 unused.
// - Two-bit priority per source from two registers.
// - Code 11 highest level, 00 lowest.
// - Lower level never preempts level in service.
// - Higher level wins among simultaneous requests.
// - Equal level ties resolved by fixed polling order.
// - Fixed vector address per source.
// - External lines: low level or falling edge.
// - Vectoring clears external flag only in edge mode.
// - Timer 0/1 flags request, cleared on vectoring.
// - Serial request is OR of rx/tx done.
// - Timer 2 request is OR of its flags.
// - Software flag writes act like hardware.
// - External 2/3 control register bit layout.
// - Low and high priority register bit layouts.
// - Trigger flag ignored in up/down reload mode.
// - No rollover request in clock-output mode.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "eic_map.svh"

module eic_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] xint_n,
  input wire logic tmr0_wrap_evt,
  input wire logic tmr1_wrap_evt,
  input wire logic tmr2_wrap_evt,
  input wire logic tmr2_trig_evt,
  input wire logic tmr2_updown_mode,
  input wire logic tmr2_clkout_mode,
  input wire logic uart_rx_evt,
  input wire logic uart_tx_evt,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [2:0] irq_source,
  output logic [1:0] irq_level,
  input wire logic irq_ack,
  input wire logic irq_reti
);

  eic_pkg::eic_state_s s_reg;
  eic_pkg::eic_state_s s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Polling position 0..7: ext0, tmr0, ext1, tmr1, serial, tmr2, ext2, ext3.
  function automatic logic [7:0] vec_of(input logic [2:0] idx);
    vec_of = `EIC_VEC_BASE + (`EIC_VEC_STEP * {5'h00, idx});
  endfunction

  function automatic eic_pkg::eic_code_t code_of(input eic_pkg::eic_state_s s, input logic [2:0] idx);
    logic lo;
    lo = 1'b0;
    if (idx == 3'h6) begin
      lo = s.x_lo[0];
    end else if (idx == 3'h7) begin
      lo = s.x_lo[1];
    end else begin
      lo = s.ip[idx];
    end
    code_of = {s.level_high_bank[idx], lo};
  endfunction

  // Highest level in service; valid flag in bit 2.
  function automatic logic [2:0] top_svc(input logic [3:0] svc);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (svc[i]) begin
        r = {1'b1, i[1:0]};
      end
    end
    top_svc = r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    is_mapped = (w == `EIC_OFS_ENABLE) || (w == `EIC_OFS_LVL_LO) || (w == `EIC_OFS_LVL_HI) ||
                (w == `EIC_OFS_XCTRL) || (w == `EIC_OFS_TFLAGS) || (w == `EIC_OFS_PFLAGS) ||
                (w == `EIC_OFS_STATUS) || (w == `EIC_OFS_REQVIEW);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state.

  logic [3:0] fall;
  logic t2_req;
  logic [7:0] raw_req;
  logic [7:0] src_en;
  logic [7:0] gated_req;
  logic found;
  logic [2:0] best_idx;
  eic_pkg::eic_code_t best_code;
  eic_pkg::eic_code_t cand;
  logic [2:0] top;
  logic [3:0] svc;
  logic [7:0] rd_byte;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] wd;
  logic wr_fire;
  logic ack_take;

  always_comb begin
    s_next = s_reg;
    cand = 2'h0;
    rd_byte = 8'h00;

    // The first stage feeds only the second; edges are taken from stages two and three.
    s_next.sync1 = xint_n;
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    fall = s_reg.sync3 & ~s_reg.sync2;

    // Request vector in polling order.
    t2_req = (s_reg.t2_wrap & ~tmr2_clkout_mode) | (s_reg.t2_trig & ~tmr2_updown_mode);
    raw_req = {s_reg.pend[3], s_reg.pend[2], t2_req,
               s_reg.rx_done | s_reg.tx_done,
               s_reg.tmr_wrap[1], s_reg.pend[1], s_reg.tmr_wrap[0], s_reg.pend[0]};
    src_en = {s_reg.x_en[1], s_reg.x_en[0], s_reg.ie[5:0]};
    gated_req = raw_req & src_en & {8{s_reg.ie[`EIC_EN_GLOBAL]}};

    // Walk from the last polling position down so an equal level keeps the earlier source.
    found = 1'b0;
    best_idx = 3'h0;
    best_code = 2'h0;
    for (int i = 7; i >= 0; i--) begin
      cand = code_of(s_reg, i[2:0]);
      if (gated_req[i] && (!found || (cand >= best_code))) begin
        found = 1'b1;
        best_idx = i[2:0];
        best_code = cand;
      end
    end

    // Return releases the newest level, which under nesting is always the highest.
    svc = s_reg.in_svc;
    if (irq_reti) begin
      top = top_svc(svc);
      if (top[2]) begin
        svc[top[1:0]] = 1'b0;
      end
    end
    ack_take = irq_ack && s_reg.req;
    if (ack_take) begin
      svc[s_reg.code] = 1'b1;
    end
    s_next.in_svc = svc;

    // A request must beat every level in service; an equal level waits too.
    top = top_svc(s_reg.in_svc);
    s_next.req = found && (!top[2] || (best_code > top[1:0])) && !ack_take && !irq_reti;
    s_next.src = best_idx;
    s_next.code = best_code;
    s_next.vec = vec_of(best_idx);

    // Vectoring clears only the flags that hardware owns.
    if (ack_take) begin
      unique case (s_reg.src)
        3'h0: begin
          if (s_reg.edge_sel[0]) s_next.pend[0] = 1'b0;
        end
        3'h2: begin
          if (s_reg.edge_sel[1]) s_next.pend[1] = 1'b0;
        end
        3'h6: begin
          if (s_reg.edge_sel[2]) s_next.pend[2] = 1'b0;
        end
        3'h7: begin
          if (s_reg.edge_sel[3]) s_next.pend[3] = 1'b0;
        end
        3'h1: begin
          s_next.tmr_wrap[0] = 1'b0;
        end
        3'h3: begin
          s_next.tmr_wrap[1] = 1'b0;
        end
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // AXI write channel.
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wstrb0 = s_axi_wstrb[0];
    end
    wr_fire = s_reg.aw_got && s_reg.w_got;
    wa = {s_reg.awaddr[7:2], 2'h0};
    wd = s_reg.wdata;
    if (wr_fire) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = is_mapped(s_reg.awaddr) ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
      if (s_reg.wstrb0) begin
        // Software writes land after the vectoring clear so a set by software survives it.
        unique case (wa)
          `EIC_OFS_ENABLE: begin
            s_next.ie = wd & `EIC_EN_WMASK;
          end
          `EIC_OFS_LVL_LO: begin
            s_next.ip = wd[5:0];
          end
          `EIC_OFS_LVL_HI: begin
            s_next.level_high_bank = wd;
          end
          `EIC_OFS_XCTRL: begin
            s_next.x_lo = {wd[`EIC_X3_LVL_LO], wd[`EIC_X2_LVL_LO]};
            s_next.x_en = {wd[`EIC_X3_IRQ_ON], wd[`EIC_X2_IRQ_ON]};
            s_next.pend[3:2] = {wd[`EIC_X3_PEND], wd[`EIC_X2_PEND]};
            s_next.edge_sel[3:2] = {wd[`EIC_X3_EDGE], wd[`EIC_X2_EDGE]};
          end
          `EIC_OFS_TFLAGS: begin
            s_next.edge_sel[1:0] = {wd[`EIC_TF_X1_EDGE], wd[`EIC_TF_X0_EDGE]};
            s_next.pend[1:0] = {wd[`EIC_TF_X1_PEND], wd[`EIC_TF_X0_PEND]};
            s_next.tmr_wrap = {wd[`EIC_TF_T1_WRAP], wd[`EIC_TF_T0_WRAP]};
          end
          `EIC_OFS_PFLAGS: begin
            s_next.rx_done = wd[`EIC_PF_RX_DONE];
            s_next.tx_done = wd[`EIC_PF_TX_DONE];
            s_next.t2_trig = wd[`EIC_PF_T2_TRIG];
            s_next.t2_wrap = wd[`EIC_PF_T2_WRAP];
          end
          default: ;
        endcase
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Hardware sets come last so an event in a clearing cycle is kept.
    if (tmr0_wrap_evt) begin
      s_next.tmr_wrap[0] = 1'b1;
    end
    if (tmr1_wrap_evt) begin
      s_next.tmr_wrap[1] = 1'b1;
    end
    if (tmr2_wrap_evt) begin
      s_next.t2_wrap = 1'b1;
    end
    if (tmr2_trig_evt) begin
      s_next.t2_trig = 1'b1;
    end
    if (uart_rx_evt) begin
      s_next.rx_done = 1'b1;
    end
    if (uart_tx_evt) begin
      s_next.tx_done = 1'b1;
    end

    // In level mode the flag mirrors the line, so software can raise it only in edge mode.
    for (int i = 0; i < 4; i++) begin
      if (!s_reg.edge_sel[i]) begin
        s_next.pend[i] = ~s_reg.sync2[i];
      end else if (fall[i]) begin
        s_next.pend[i] = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // AXI read channel.
    ra = {s_axi_araddr[7:2], 2'h0};
    if (s_axi_arvalid && s_axi_arready) begin
      unique case (ra)
        `EIC_OFS_ENABLE: begin
          rd_byte = s_reg.ie;
        end
        `EIC_OFS_LVL_LO: begin
          rd_byte = {2'h0, s_reg.ip};
        end
        `EIC_OFS_LVL_HI: begin
          rd_byte = s_reg.level_high_bank;
        end
        `EIC_OFS_XCTRL: begin
          rd_byte[`EIC_X3_LVL_LO] = s_reg.x_lo[1];
          rd_byte[`EIC_X3_IRQ_ON] = s_reg.x_en[1];
          rd_byte[`EIC_X3_PEND] = s_reg.pend[3];
          rd_byte[`EIC_X3_EDGE] = s_reg.edge_sel[3];
          rd_byte[`EIC_X2_LVL_LO] = s_reg.x_lo[0];
          rd_byte[`EIC_X2_IRQ_ON] = s_reg.x_en[0];
          rd_byte[`EIC_X2_PEND] = s_reg.pend[2];
          rd_byte[`EIC_X2_EDGE] = s_reg.edge_sel[2];
        end
        `EIC_OFS_TFLAGS: begin
          rd_byte[`EIC_TF_T1_WRAP] = s_reg.tmr_wrap[1];
          rd_byte[`EIC_TF_T0_WRAP] = s_reg.tmr_wrap[0];
          rd_byte[`EIC_TF_X1_PEND] = s_reg.pend[1];
          rd_byte[`EIC_TF_X1_EDGE] = s_reg.edge_sel[1];
          rd_byte[`EIC_TF_X0_PEND] = s_reg.pend[0];
          rd_byte[`EIC_TF_X0_EDGE] = s_reg.edge_sel[0];
        end
        `EIC_OFS_PFLAGS: begin
          rd_byte[`EIC_PF_T2_WRAP] = s_reg.t2_wrap;
          rd_byte[`EIC_PF_T2_TRIG] = s_reg.t2_trig;
          rd_byte[`EIC_PF_TX_DONE] = s_reg.tx_done;
          rd_byte[`EIC_PF_RX_DONE] = s_reg.rx_done;
        end
        `EIC_OFS_STATUS: rd_byte = {s_reg.req, s_reg.src, s_reg.in_svc};
        `EIC_OFS_REQVIEW: rd_byte = gated_req;
        default: rd_byte = 8'h00;
      endcase
      s_next.rvalid = 1'b1;
      s_next.rdata = {24'h000000, rd_byte};
      s_next.rresp = is_mapped(s_axi_araddr[7:0]) ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.sync1 <= `EIC_RST_LINES;
      s_reg.sync2 <= `EIC_RST_LINES;
      s_reg.sync3 <= `EIC_RST_LINES;
      s_reg.vec <= `EIC_VEC_BASE;
      s_reg.ie <= `EIC_RST_BYTE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign s_axi_awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign s_axi_wready = ~s_reg.w_got & ~s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = ~s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign irq_req = s_reg.req;
  assign irq_vector = s_reg.vec;
  assign irq_source = s_reg.src;
  assign irq_level = s_reg.code;

endmodule

// >>> sim/eic_ctrl_props.sv
`timescale 1ns/100ps
module eic_ctrl_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [2:0] irq_source,
  input wire logic [1:0] irq_level,
  input wire logic irq_ack,
  input wire logic irq_reti
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // Any return clears the tracker, so nesting is judged one level deep only; that is weaker but never wrong.
  logic svc_reg;
  logic [1:0] lvl_reg;
  always_ff @(posedge sys_clk) begin
    if (srst || irq_reti)
      svc_reg <= 1'b0;
    else if (irq_ack && irq_req)
      svc_reg <= 1'b1;
    if (irq_ack && irq_req)
      lvl_reg <= irq_level;
  end
  ////////////////////////////////////////////////////////////////
  property p_ack_drop; irq_ack && irq_req |=> !irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
  property p_reti_drop; irq_reti |=> !irq_req; endproperty
  a_reti_drop: assert property (p_reti_drop) else $error("request held after return");
  property p_vector; irq_req |-> irq_vector == 8'h03 + {2'h0, irq_source, 3'h0}; endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source");
  property p_no_preempt; svc_reg && irq_req |-> irq_level > lvl_reg; endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("request not above level in service");
  // Both channels latch first and the write lands one edge later, so the answer is two edges out.
  property p_wr_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while answering");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late or wide");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  c_ack: cover property (irq_ack && irq_req);
  c_nest: cover property (svc_reg && irq_ack && irq_req);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind eic_ctrl eic_ctrl_props eic_ctrl_props_i (.sys_clk, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_vector, .irq_source, .irq_level,
  .irq_ack, .irq_reti);

// >>> sim/eic_core_model.sv
`timescale 1ns/100ps
module eic_core_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic hold,
  input wire logic ret_go,
  output logic irq_ack,
  output logic irq_reti,
  output logic [7:0] got_vec,
  output int got_cnt
);
  // Hold stalls the core so several requests can pile up before one is taken.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_ack <= 1'b0;
      irq_reti <= 1'b0;
      got_vec <= 8'h00;
      got_cnt <= 0;
    end else begin
      irq_ack <= irq_req && !irq_ack && !hold;
      irq_reti <= ret_go;
      if (irq_ack && irq_req) begin
        got_vec <= irq_vector;
        got_cnt <= got_cnt + 1;
      end
    end
  end
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`include "eic_map.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] xint_n = 4'hf;
  logic [5:0] evt = 6'h00;
  logic updn = 1'b0, clko = 1'b0, hold = 1'b0, ret = 1'b0;
  logic irq_req, irq_ack, irq_reti;
  logic [7:0] irq_vector, got_vec;
  logic [2:0] irq_source;
  logic [1:0] irq_level;
  int got_cnt;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [7:0] ofs [4] = '{`EIC_OFS_ENABLE, `EIC_OFS_LVL_LO, `EIC_OFS_LVL_HI, `EIC_OFS_XCTRL};
  localparam logic [7:0] wv [4] = '{8'hff, 8'hff, 8'ha5, 8'hdd};
  localparam logic [7:0] ev [4] = '{8'hbf, 8'h3f, 8'ha5, 8'hdd};

  always #10 sys_clk = ~sys_clk;

  eic_ctrl eic_ctrl_i (
    .sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xint_n,
    .tmr0_wrap_evt(evt[0]), .tmr1_wrap_evt(evt[1]), .tmr2_wrap_evt(evt[2]), .tmr2_trig_evt(evt[3]),
    .tmr2_updown_mode(updn), .tmr2_clkout_mode(clko), .uart_rx_evt(evt[4]), .uart_tx_evt(evt[5]),
    .irq_req, .irq_vector, .irq_source, .irq_level, .irq_ack, .irq_reti
  );
  eic_core_model eic_core_model_i (
    .sys_clk, .srst, .irq_req, .irq_vector, .hold, .ret_go(ret), .irq_ack, .irq_reti, .got_vec, .got_cnt
  );
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    chk({s_axi_bresp, 32'h0}, 34'h0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
  endtask

  task automatic expv(input logic [7:0] v);
    int n;
    n = got_cnt;
    for (int i = 0; i < 40 && got_cnt == n; i++)
      @(posedge sys_clk);
    chk(34'(got_cnt - n), 34'd1);
    chk(34'(got_vec), 34'(v));
  endtask

  task automatic none();
    int n;
    n = got_cnt;
    repeat (12) @(posedge sys_clk);
    chk(34'(got_cnt - n), 34'd0);
  endtask

  task automatic pulse(input logic [5:0] e);
    evt <= e;
    @(posedge sys_clk);
    evt <= 6'h00;
  endtask

  task automatic back();
    ret <= 1'b1;
    @(posedge sys_clk);
    ret <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      rd_chk(ofs[i], 8'h00, `EIC_RESP_OKAY);
      wr(ofs[i], wv[i]);
      rd_chk(ofs[i], ev[i], `EIC_RESP_OKAY);
      wr(ofs[i], 8'h00);
    end
    rd_chk(8'h20, 8'h00, `EIC_RESP_SLVERR);
    // Stalled core: all three flags are pending together when it looks.
    wr(`EIC_OFS_ENABLE, 8'hbf);
    wr(`EIC_OFS_LVL_HI, 8'h10);
    hold <= 1'b1;
    pulse(6'h23);
    repeat (3) @(posedge sys_clk);
    hold <= 1'b0;
    expv(8'h23);
    none();
    // Serial at level code 2 in service, source 4 still winning, timers 0 and 1 and serial enabled and pending.
    rd_chk(`EIC_OFS_STATUS, 8'h44, `EIC_RESP_OKAY);
    rd_chk(`EIC_OFS_REQVIEW, 8'h1a, `EIC_RESP_OKAY);
    back();
    expv(8'h23);
    wr(`EIC_OFS_PFLAGS, 8'h00);
    back();
    expv(8'h0b);
    back();
    expv(8'h1b);
    back();
    none();
    wr(`EIC_OFS_ENABLE, 8'h3f);
    wr(`EIC_OFS_TFLAGS, 8'ha0);
    none();
    wr(`EIC_OFS_ENABLE, 8'h88);
    expv(8'h1b);
    back();
    wr(`EIC_OFS_TFLAGS, 8'h01);
    wr(`EIC_OFS_ENABLE, 8'h85);
    xint_n <= 4'he;
    expv(8'h03);
    xint_n <= 4'hc;
    repeat (5) @(posedge sys_clk);
    rd_chk(`EIC_OFS_TFLAGS, 8'h09, `EIC_RESP_OKAY);
    back();
    expv(8'h13);
    rd_chk(`EIC_OFS_TFLAGS, 8'h09, `EIC_RESP_OKAY);
    xint_n <= 4'hf;
    repeat (5) @(posedge sys_clk);
    rd_chk(`EIC_OFS_TFLAGS, 8'h01, `EIC_RESP_OKAY);
    back();
    none();
    wr(`EIC_OFS_XCTRL, 8'h44);
    wr(`EIC_OFS_LVL_HI, 8'h80);
    xint_n <= 4'h3;
    expv(8'h3b);
    xint_n <= 4'hb;
    repeat (5) @(posedge sys_clk);
    back();
    expv(8'h33);
    xint_n <= 4'hf;
    repeat (5) @(posedge sys_clk);
    back();
    none();
    wr(`EIC_OFS_ENABLE, 8'ha0);
    updn <= 1'b1;
    clko <= 1'b1;
    pulse(6'h0c);
    none();
    updn <= 1'b0;
    expv(8'h2b);
    wr(`EIC_OFS_PFLAGS, 8'h80);
    back();
    none();
    clko <= 1'b0;
    expv(8'h2b);
    wr(`EIC_OFS_PFLAGS, 8'h00);
    back();
    none();
    report_and_stop();
  end
endmodule
